// File: src/radio_test_pkg.sv
// constants for the radio test and buffer access register bank
package radio_test_pkg;
  // register addresses
  localparam logic [7:0] addr_conv_test    = 8'h2d;
  localparam logic [7:0] addr_tx_conv_test = 8'h2e;
  localparam logic [7:0] addr_top_test     = 8'h2f;
  localparam logic [7:0] addr_spare_bits   = 8'h30;
  localparam logic [7:0] addr_tx_buffer    = 8'h3e;
  localparam logic [7:0] addr_rx_buffer    = 8'h3f;
  // converter test fields
  localparam int conv_clk_gate_bit = 15;
  localparam int conv_i_lsb        = 8;
  localparam int conv_q_lsb        = 0;
  localparam int sample_w          = 7;
  // transmit converter test fields
  localparam int src_lsb           = 12;
  localparam int ovr_i_lsb         = 6;
  localparam int ovr_q_lsb         = 0;
  localparam int ovr_w             = 6;
  // top test fields
  localparam int selftest_bit      = 7;
  localparam int battmon_bit       = 6;
  localparam int vc_dir_bit        = 5;
  localparam int atest_pd_bit      = 4;
  localparam int route_lsb         = 0;
  // reset values
  localparam logic [15:0] top_test_reset = 16'h0010;
  localparam logic [15:0] zero16         = 16'h0000;
  localparam logic [7:0]  zero8          = 8'h00;
  // analog test route codes
  localparam logic [3:0] route_vc_node = 4'h7;
  localparam logic [3:0] route_max     = 4'h8;
  // transmit converter source codes
  typedef enum logic [2:0] {
    src_modulator, src_override, src_rx_high, src_filtered,
    src_noise, src_rx_low, src_magnitude, src_diag
  } tx_src_e;
endpackage

// File: src/radio_test_regs.sv
// test and buffer access register bank of the radio transceiver
////////////////////////////////////////////////////////////////////////////////

// Overview of operation
// - bit 15 stops receive converter clock
// - bits 14:8 read live I sample
// - bits 6:0 read live Q sample
// - source field selects transmit converter feed
// - override mode uses bits 11:6, 5:0
// - bit 7 starts buffer memory self-test
// - bit 6 enables battery monitor test
// - bit 4 powers down test module
// - route field active only when powered
// - route 7: bit 5 sets node direction
// - spare 16-bit register at 0x30
// - 0x3e write pushes transmit byte
// - 0x3f reads and writes receive bytes
module radio_test_regs (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        conv_enable,
  input  wire logic [6:0]  conv_i_sample,
  input  wire logic [6:0]  conv_q_sample,
  output logic             conv_clk_run,
  input  wire logic [5:0]  mod_i,
  input  wire logic [5:0]  mod_q,
  input  wire logic [5:0]  filt_i,
  input  wire logic [5:0]  filt_q,
  input  wire logic [5:0]  noise_val,
  input  wire logic [5:0]  magnitude_val,
  input  wire logic [5:0]  diag_i,
  input  wire logic [5:0]  diag_q,
  output logic      [5:0]  tx_conv_i,
  output logic      [5:0]  tx_conv_q,
  output logic             buffer_selftest_run,
  output logic             battery_monitor_test_out,
  output logic             analog_test_powerdown,
  output logic      [3:0]  analog_test_route,
  output logic             analog_test_active,
  output logic             vc_node_direction,
  output logic      [7:0]  tx_buffer_port,
  output logic             tx_buffer_valid,
  input  wire logic        tx_buffer_ready,
  output logic             tx_buffer_stall,
  input  wire logic [7:0]  rx_buffer_port,
  input  wire logic        rx_buffer_valid,
  output logic             rx_buffer_ready,
  output logic      [7:0]  rx_write_byte,
  output logic             rx_write_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  wire logic wr_conv  = reg_wr && hit(reg_addr, radio_test_pkg::addr_conv_test);
  wire logic wr_txc   = reg_wr && hit(reg_addr, radio_test_pkg::addr_tx_conv_test);
  wire logic wr_top   = reg_wr && hit(reg_addr, radio_test_pkg::addr_top_test);
  wire logic wr_spare = reg_wr && hit(reg_addr, radio_test_pkg::addr_spare_bits);
  wire logic wr_txb   = reg_wr && hit(reg_addr, radio_test_pkg::addr_tx_buffer);
  wire logic wr_rxb   = reg_wr && hit(reg_addr, radio_test_pkg::addr_rx_buffer);
  wire logic rd_rxb   = reg_rd && hit(reg_addr, radio_test_pkg::addr_rx_buffer);

  // register storage
  logic        conv_clk_gate;
  logic [14:0] tx_conv_test;
  logic [7:0]  top_test;
  logic [15:0] spare_bits;

  ////////////////////////////////////////////////////////////////////////////
  // writable fields; read-only sample bits are never stored
  // clock gate bit
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conv_clk_gate <= 1'b0;
    end else if (wr_conv) begin
      conv_clk_gate <= reg_wdata[radio_test_pkg::conv_clk_gate_bit];
    end
  end

  // source and overrides; reserved bit 15 dropped
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_conv_test <= radio_test_pkg::zero16[14:0];
    end else if (wr_txc) begin
      tx_conv_test <= reg_wdata[14:0];
    end
  end

  // top test controls; reserved upper byte dropped
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      top_test <= radio_test_pkg::top_test_reset[7:0];
    end else if (wr_top) begin
      top_test <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      spare_bits <= radio_test_pkg::zero16;
    end else if (wr_spare) begin
      spare_bits <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field views
  wire logic [2:0] src_sel = tx_conv_test[radio_test_pkg::src_lsb +: 3];
  wire logic [5:0] ovr_i   = tx_conv_test[radio_test_pkg::ovr_i_lsb +: radio_test_pkg::ovr_w];
  wire logic [5:0] ovr_q   = tx_conv_test[radio_test_pkg::ovr_q_lsb +: radio_test_pkg::ovr_w];
  wire logic [3:0] route   = top_test[radio_test_pkg::route_lsb +: 4];
  wire logic       pd      = top_test[radio_test_pkg::atest_pd_bit];
  radio_test_pkg::tx_src_e tx_conv_source_sel;
  assign tx_conv_source_sel = radio_test_pkg::tx_src_e'(src_sel);

  logic [5:0] next_tx_i;
  logic [5:0] next_tx_q;
  always_comb begin
    case (tx_conv_source_sel)
      radio_test_pkg::src_modulator: begin
        next_tx_i = mod_i;
        next_tx_q = mod_q;
      end
      radio_test_pkg::src_override: begin
        next_tx_i = ovr_i;
        next_tx_q = ovr_q;
      end
      radio_test_pkg::src_rx_high: begin
        next_tx_i = conv_i_sample[6:1];
        next_tx_q = conv_q_sample[6:1];
      end
      radio_test_pkg::src_filtered: begin
        next_tx_i = filt_i;
        next_tx_q = filt_q;
      end
      radio_test_pkg::src_noise: begin
        next_tx_i = noise_val;
        next_tx_q = ~noise_val;
      end
      radio_test_pkg::src_rx_low: begin
        next_tx_i = conv_i_sample[5:0];
        next_tx_q = conv_q_sample[5:0];
      end
      radio_test_pkg::src_magnitude: begin
        next_tx_i = magnitude_val;
        next_tx_q = magnitude_val;
      end
      radio_test_pkg::src_diag: begin
        next_tx_i = diag_i;
        next_tx_q = diag_q;
      end
      default: begin
        next_tx_i = mod_i;
        next_tx_q = mod_q;
      end
    endcase
  end

  // route valid only when powered up and code in range
  wire logic next_active = !pd && (route <= radio_test_pkg::route_max);

  ////////////////////////////////////////////////////////////////////////////
  // two-entry transmit buffer; write pushes one byte
  logic [7:0] tx_mem [2];
  logic       tx_wp;
  logic       tx_rp;
  logic [1:0] tx_cnt;
  wire logic  tx_full  = (tx_cnt == 2'h2);
  wire logic  tx_push  = wr_txb && !tx_full;
  wire logic  tx_pop   = (tx_cnt != 2'h0) && tx_buffer_ready;
  wire logic [1:0] next_tx_cnt = tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop};

  // buffer pointers and count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_wp  <= 1'b0;
      tx_rp  <= 1'b0;
      tx_cnt <= 2'h0;
    end else begin
      if (tx_push) tx_wp <= ~tx_wp;
      if (tx_pop) tx_rp <= ~tx_rp;
      tx_cnt <= next_tx_cnt;
    end
  end

  // buffer storage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_mem[0] <= radio_test_pkg::zero8;
      tx_mem[1] <= radio_test_pkg::zero8;
    end else if (tx_push) begin
      tx_mem[tx_wp] <= reg_wdata[7:0];
    end
  end

  // next head of buffer
  wire logic       next_tx_valid = (next_tx_cnt != 2'h0);
  wire logic       head_idx      = tx_pop ? ~tx_rp : tx_rp;
  wire logic [7:0] next_tx_head  = (tx_cnt == 2'h0) ? reg_wdata[7:0]
                                 : (tx_pop && tx_cnt == 2'h1) ? reg_wdata[7:0]
                                 : tx_mem[head_idx];

  ////////////////////////////////////////////////////////////////////////////
  // two-entry receive buffer; reads pop bytes in order
  logic [7:0] rx_mem [2];
  logic       rx_wp;
  logic       rx_rp;
  logic [1:0] rx_cnt;
  // handshake with the far side and with register reads
  wire logic  rx_fill = rx_buffer_valid && rx_buffer_ready;
  wire logic  rx_have = (rx_cnt != 2'h0);
  wire logic  rx_take = rd_rxb && rx_have;
  wire logic [1:0] next_rx_cnt = rx_cnt + {1'b0, rx_fill} - {1'b0, rx_take};
  wire logic [7:0] rx_head     = rx_mem[rx_rp];

  // receive pointers and count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_wp  <= 1'b0;
      rx_rp  <= 1'b0;
      rx_cnt <= 2'h0;
    end else begin
      if (rx_fill) rx_wp <= ~rx_wp;
      if (rx_take) rx_rp <= ~rx_rp;
      rx_cnt <= next_rx_cnt;
    end
  end

  // receive storage, filled only while an entry is free
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_mem[0] <= radio_test_pkg::zero8;
      rx_mem[1] <= radio_test_pkg::zero8;
    end else if (rx_fill) begin
      rx_mem[rx_wp] <= rx_buffer_port;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = radio_test_pkg::zero16;
    if (reg_rd) begin
      case (reg_addr)
        radio_test_pkg::addr_conv_test:
          next_rdata = {conv_clk_gate, conv_i_sample, 1'b0, conv_q_sample};
        radio_test_pkg::addr_tx_conv_test: next_rdata = {1'b0, tx_conv_test};
        radio_test_pkg::addr_top_test:     next_rdata = {8'h00, top_test};
        radio_test_pkg::addr_spare_bits:   next_rdata = spare_bits;
        radio_test_pkg::addr_rx_buffer:
          next_rdata = rx_have ? {8'h00, rx_head} : radio_test_pkg::zero16;
        default: next_rdata = radio_test_pkg::zero16;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered read data, stands one cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= radio_test_pkg::zero16;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // clock runs when enabled and not gated
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conv_clk_run <= 1'b0;
    end else begin
      conv_clk_run <= conv_enable && !conv_clk_gate;
    end
  end

  // selected converter feed, one cycle late
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_conv_i <= 6'h00;
      tx_conv_q <= 6'h00;
    end else begin
      tx_conv_i <= next_tx_i;
      tx_conv_q <= next_tx_q;
    end
  end

  // self-test start and battery monitor test
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      buffer_selftest_run      <= 1'b0;
      battery_monitor_test_out <= 1'b0;
    end else begin
      buffer_selftest_run      <= top_test[radio_test_pkg::selftest_bit];
      battery_monitor_test_out <= top_test[radio_test_pkg::battmon_bit];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      analog_test_powerdown <= 1'b1;
      analog_test_route     <= 4'h0;
      analog_test_active    <= 1'b0;
    end else begin
      analog_test_powerdown <= pd;
      analog_test_route     <= route;
      analog_test_active    <= next_active;
    end
  end

  // node direction only in route 7
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      vc_node_direction <= 1'b0;
    end else begin
      vc_node_direction <= next_active && (route == radio_test_pkg::route_vc_node)
                           && top_test[radio_test_pkg::vc_dir_bit];
    end
  end

  // head byte and fill state towards the far side
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_buffer_port  <= radio_test_pkg::zero8;
      tx_buffer_valid <= 1'b0;
      tx_buffer_stall <= 1'b0;
    end else begin
      tx_buffer_port  <= next_tx_head;
      tx_buffer_valid <= next_tx_valid;
      tx_buffer_stall <= (next_tx_cnt == 2'h2);
    end
  end

  // receive space; low out of reset only delays the first fill
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_buffer_ready <= 1'b0;
    end else begin
      rx_buffer_ready <= (next_rx_cnt != 2'h2);
    end
  end

  // byte writes to the receive address
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_write_byte   <= radio_test_pkg::zero8;
      rx_write_strobe <= 1'b0;
    end else begin
      rx_write_byte   <= wr_rxb ? reg_wdata[7:0] : rx_write_byte;
      rx_write_strobe <= wr_rxb;
    end
  end

endmodule

// File: dv/radio_test_checker.sv
// assertion checker for the radio test register bank
module radio_test_checker (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        conv_enable,
  input wire logic [6:0]  conv_i_sample,
  input wire logic [6:0]  conv_q_sample,
  input wire logic        conv_clk_run,
  input wire logic [5:0]  mod_i,
  input wire logic [5:0]  tx_conv_i,
  input wire logic        analog_test_powerdown,
  input wire logic [7:0]  tx_buffer_port,
  input wire logic        tx_buffer_valid,
  input wire logic [7:0]  rx_write_byte,
  input wire logic        rx_write_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // access decode
  wire w2d = reg_wr && reg_addr == 8'h2d;
  wire w2e = reg_wr && reg_addr == 8'h2e;
  wire w2f = reg_wr && reg_addr == 8'h2f;
  wire w30 = reg_wr && reg_addr == 8'h30;
  wire r30 = reg_rd && reg_addr == 8'h30;
  logic [15:0] spare_m;
  // shadow of the spare word
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      spare_m <= 16'h0000;
    end else if (w30) begin
      spare_m <= reg_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_CLK_OFF: assert property (!conv_enable |=> !conv_clk_run)
    else $error("converter clock runs while disabled");
  AST_GATE: assert property (w2d && reg_wdata[15] ##1 !reg_wr |=> !conv_clk_run)
    else $error("converter clock not gated");
  AST_SAMPLE: assert property (reg_rd && reg_addr == 8'h2d |=>
    reg_rdata[14:0] == {$past(conv_i_sample), 1'b0, $past(conv_q_sample)})
    else $error("sample readback wrong");
  AST_SRC_MOD: assert property (w2e && reg_wdata[14:12] == 3'h0 ##1 !reg_wr
    |=> tx_conv_i == $past(mod_i)) else $error("modulator feed wrong");
  AST_OVERRIDE: assert property (w2e && reg_wdata[14:12] == 3'h1 ##1 !reg_wr
    |=> tx_conv_i == $past(reg_wdata[11:6], 2)) else $error("override feed wrong");
  AST_POWERDOWN: assert property (w2f ##1 !reg_wr
    |=> analog_test_powerdown == $past(reg_wdata[4], 2)) else $error("powerdown wrong");
  AST_SPARE: assert property (r30 |=> reg_rdata == spare_m)
    else $error("spare readback wrong");
  AST_TX_PUSH: assert property (reg_wr && reg_addr == 8'h3e && !tx_buffer_valid
    |=> tx_buffer_valid && tx_buffer_port == $past(reg_wdata[7:0]))
    else $error("transmit byte not pushed");
  AST_RX_WR: assert property (reg_wr && reg_addr == 8'h3f
    |=> rx_write_strobe && rx_write_byte == $past(reg_wdata[7:0]))
    else $error("receive byte write lost");
  // main scenarios
  cover property (reg_wr && reg_addr == 8'h3e && tx_buffer_valid);
  cover property (reg_rd && reg_addr == 8'h3f);
  cover property (w2f ##1 !reg_wr);
endmodule

bind radio_test_regs radio_test_checker chk_i (.mclk, .arst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .conv_enable, .conv_i_sample, .conv_q_sample,
  .conv_clk_run, .mod_i, .tx_conv_i, .analog_test_powerdown, .tx_buffer_port,
  .tx_buffer_valid, .rx_write_byte, .rx_write_strobe);

// File: dv/buffer_far_side.sv
// far side model: transmit byte sink and receive byte source
module buffer_far_side (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        stall,
  input  wire logic [7:0]  tx_buffer_port,
  input  wire logic        tx_buffer_valid,
  output logic             tx_buffer_ready,
  input  wire logic        rx_buffer_ready,
  output logic      [7:0]  rx_buffer_port,
  output logic             rx_buffer_valid,
  output logic      [15:0] seen,
  output logic      [15:0] far_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  // sink stalls on request, source always has a byte
  assign tx_buffer_ready = !stall;
  assign rx_buffer_valid = arst_n;
  // collect popped bytes, advance source on consume
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      seen <= 16'h0000;
      far_cnt <= 16'h0000;
      rx_buffer_port <= 8'ha0;
    end else begin
      if (tx_buffer_valid && tx_buffer_ready) begin
        seen <= {seen[7:0], tx_buffer_port};
        far_cnt <= far_cnt + 16'h0001;
      end
      if (rx_buffer_ready && rx_buffer_valid) begin
        rx_buffer_port <= rx_buffer_port + 8'h01;
      end
    end
  end
endmodule

// File: dv/radio_test_regs_tb.sv
// self-checking bench for the radio test register bank
module radio_test_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        conv_enable = 1'b0, stall = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [6:0]  smp_i = 7'h5a, smp_q = 7'h25;
  logic [5:0]  mod_i = 6'h01, filt_i = 6'h03, noise = 6'h04, mag = 6'h06, diag = 6'h07;
  logic [15:0] reg_rdata, seen, far_cnt;
  logic [7:0]  tx_p, rx_p, rx_wb;
  logic [5:0]  tx_i, tx_q;
  logic [3:0]  route;
  logic        run, st, bm, pd, act, vcd, tx_v, tx_r, stl, rx_v, rx_r, rx_ws;
  int          err_total = 0, n_tests = 0;
  radio_test_regs dut (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .conv_enable, .conv_i_sample(smp_i), .conv_q_sample(smp_q), .conv_clk_run(run),
    .mod_i, .mod_q(~mod_i), .filt_i, .filt_q(~filt_i), .noise_val(noise),
    .magnitude_val(mag), .diag_i(diag), .diag_q(~diag), .tx_conv_i(tx_i), .tx_conv_q(tx_q),
    .buffer_selftest_run(st), .battery_monitor_test_out(bm), .analog_test_powerdown(pd),
    .analog_test_route(route), .analog_test_active(act), .vc_node_direction(vcd),
    .tx_buffer_port(tx_p), .tx_buffer_valid(tx_v), .tx_buffer_ready(tx_r),
    .tx_buffer_stall(stl), .rx_buffer_port(rx_p), .rx_buffer_valid(rx_v),
    .rx_buffer_ready(rx_r), .rx_write_byte(rx_wb), .rx_write_strobe(rx_ws));
  buffer_far_side far (.mclk, .arst_n, .stall, .tx_buffer_port(tx_p), .tx_buffer_valid(tx_v),
    .tx_buffer_ready(tx_r), .rx_buffer_ready(rx_r), .rx_buffer_port(rx_p),
    .rx_buffer_valid(rx_v), .seen, .far_cnt);
  initial forever #2 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_conv;
    @(posedge mclk);
    conv_enable <= 1'b1;
    rd(8'h2f, 16'h0010);
    wr(8'h30, 16'hbeef);
    rd(8'h30, 16'hbeef);
    rd(8'h31, 16'h0000);
    wr(8'h2d, 16'hff7f);
    settle;
    chk("clk_run", 16'h0, run);
    rd(8'h2d, {1'b1, smp_i, 1'b0, smp_q});
    wr(8'h2d, 16'h0000);
    settle;
    chk("clk_run", 16'h1, run);
    $display("converter test done");
  endtask
  task automatic t_src;
    logic [5:0] ex [8];
    ex = '{mod_i, 6'h15, smp_i[6:1], filt_i, noise, smp_i[5:0], mag, diag};
    wr(8'h2f, 16'h0004);
    for (int k = 0; k < 8; k++) begin
      wr(8'h2e, {1'b0, k[2:0], 6'h15, 6'h2a});
      settle;
      chk("tx_i", {10'h0, ex[k]}, {10'h0, tx_i});
    end
    wr(8'h2e, 16'h1555);
    settle;
    chk("tx_q", 16'h15, {10'h0, tx_q});
    rd(8'h2e, 16'h1555);
    $display("source test done");
  endtask
  task automatic t_top;
    logic [15:0] wv [6] = '{16'h00e7, 16'h0027, 16'h0037, 16'h0029, 16'h0008, 16'h0007};
    logic [4:0]  ev [6] = '{5'h1d, 5'h05, 5'h02, 5'h00, 5'h01, 5'h01};
    for (int k = 0; k < 6; k++) begin
      wr(8'h2f, wv[k]);
      settle;
      chk("top_out", {11'h0, ev[k]}, {11'h0, st, bm, vcd, pd, act});
      chk("route", {12'h0, wv[k][3:0]}, {12'h0, route});
    end
    rd(8'h2f, 16'h0007);
    $display("top test done");
  endtask
  task automatic t_buf;
    int cnt;
    @(posedge mclk);
    stall <= 1'b1;
    for (int k = 1; k < 4; k++) begin
      @(posedge mclk);
      reg_addr <= 8'h3e;
      reg_wdata <= {8'h00, 8'(k * 17)};
      reg_wr <= 1'b1;
    end
    @(posedge mclk);
    reg_wr <= 1'b0;
    settle;
    chk("stall", 16'h1, {15'h0, stl});
    rd(8'h3e, 16'h0000);
    @(posedge mclk);
    stall <= 1'b0;
    for (cnt = 0; cnt < 20 && far_cnt < 16'h2; cnt++) @(posedge mclk);
    if (cnt == 20) begin
      chk("drain_wait", 16'h0000, 16'h0014);
      wrap_up;
    end
    settle;
    chk("drained", 16'h1122, seen);
    chk("count", 16'h2, far_cnt);
    rd(8'h3f, 16'h00a0);
    rd(8'h3f, 16'h00a1);
    wr(8'h3f, 16'h005c);
    #1 chk("rx_byte", 16'h015c, {7'h0, rx_ws, rx_wb});
    $display("buffer test done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    t_conv;
    t_src;
    t_top;
    t_buf;
    wrap_up;
  end
endmodule
